/* hw/sudc_cfg.svh */
// Purpose: offsets, field positions and reset values of the counter block
// Assumes: byte addresses on a 32-bit avalon-mm slave, one word per register
// Notes:   definitions only
`ifndef SUDC_CFG_SVH
`define SUDC_CFG_SVH

// register byte offsets
`define SUDC_CTRL_OFS 4'h0
`define SUDC_DATA_OFS 4'h4
`define SUDC_CMD_OFS 4'h8
`define SUDC_STAT_OFS 4'hC

// ctrl field positions
`define SUDC_CTRL_SRC_BIT 0
`define SUDC_CTRL_UP_BIT 1
`define SUDC_CTRL_ENP_BIT 2
`define SUDC_CTRL_ENT_BIT 3

// cmd field positions
`define SUDC_CMD_LOAD_BIT 0

// status field positions
`define SUDC_STAT_CARRY_BIT 4
`define SUDC_STAT_DEC_BIT 5

// reset values: pin source, counting down, both enables off
`define SUDC_CTRL_RST 4'hC
`define SUDC_DATA_RST 4'h0
`define SUDC_COUNT_RST 4'h0

// terminal counts
`define SUDC_DEC_MAX 4'h9
`define SUDC_BIN_MAX 4'hF

`endif

/* hw/sudc_pkg.sv */
// Purpose: types and shared helpers of the counter block
// Assumes: counter width of four bits
// Notes:   constants live in sudc_cfg.svh
`include "sudc_cfg.svh"

package sudc_pkg;

  typedef logic [3:0] sudc_count_t;

  // operating mode chosen at each edge
  typedef enum logic [1:0] {
    SUDC_MODE_HOLD = 2'b00,
    SUDC_MODE_LOAD = 2'b01,
    SUDC_MODE_UP = 2'b10,
    SUDC_MODE_DOWN = 2'b11
  } sudc_mode_e;

  // bus slave states
  typedef enum logic [0:0] {
    SUDC_BUS_IDLE = 1'b0,
    SUDC_BUS_ACK = 1'b1
  } sudc_bus_e;

  // highest value of the count sequence
  function automatic sudc_count_t sudc_max(input logic decade);
    sudc_max = decade ? `SUDC_DEC_MAX : `SUDC_BIN_MAX;
  endfunction : sudc_max

  // terminal count: top when counting up, zero when counting down
  function automatic logic sudc_is_term(input sudc_count_t cnt, input logic up,
                                        input logic decade);
    sudc_is_term = up ? (cnt == sudc_max(decade)) : (cnt == `SUDC_COUNT_RST);
  endfunction : sudc_is_term

endpackage : sudc_pkg

/* hw/sudc_next.sv */
// Purpose: next-count arithmetic of the counter
// Assumes: count and data are four bits
// Notes:   purely combinational
`timescale 1ns/1ns
`include "sudc_cfg.svh"

module sudc_next
  import sudc_pkg::*;
#(
  parameter bit DECADE = 1'b1
) (
  input wire sudc_count_t cnt_i,
  input wire sudc_count_t data_i,
  input wire sudc_mode_e mode_i,
  output sudc_count_t nxt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // step values, wrapping at the ends of the sequence
  wire sudc_count_t inc_w = sudc_is_term(cnt_i, 1'b1, DECADE) ? `SUDC_COUNT_RST
                            : sudc_count_t'(cnt_i + 4'h1);
  wire sudc_count_t dec_w = sudc_is_term(cnt_i, 1'b0, DECADE) ? sudc_max(DECADE)
                            : sudc_count_t'(cnt_i - 4'h1);

  // mode select; out-of-range decade states just step and recover
  always_comb begin
    case (mode_i)
      SUDC_MODE_LOAD: nxt_o = data_i;
      SUDC_MODE_UP: nxt_o = inc_w;
      SUDC_MODE_DOWN: nxt_o = dec_w;
      SUDC_MODE_HOLD: nxt_o = cnt_i;
      default: nxt_o = cnt_i;
    endcase
  end

endmodule : sudc_next

/* hw/sudc_avs.sv */
// Purpose: avalon-mm slave front end with one wait state
// Assumes: master holds its request until waitrequest is low
// Notes:   gives an access flag, one write strobe and a read-select to the core; address decode is left to the core
`timescale 1ns/1ns

module sudc_avs
  import sudc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  output logic avs_waitrequest_o,
  output logic acc_o,
  output logic wr_o,
  output logic rd_o
);

  sudc_bus_e state_r;
  sudc_bus_e state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // first cycle of a request waits; the second completes it
  wire req_w = avs_read_i | avs_write_i;
  assign state_nxt = (state_r == SUDC_BUS_IDLE && req_w) ? SUDC_BUS_ACK : SUDC_BUS_IDLE;
  assign acc_o = (state_r == SUDC_BUS_ACK) & ce_i;
  assign avs_waitrequest_o = req_w & ~acc_o;
  assign wr_o = acc_o & avs_write_i;
  assign rd_o = (state_r == SUDC_BUS_IDLE) & avs_read_i & ce_i;

  // frozen with ce low, so the wait simply stretches
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= SUDC_BUS_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

endmodule : sudc_avs

/* hw/sudc_top.sv */
// Purpose: four-bit synchronous presettable up/down counter, decade or binary
// Assumes: all pin inputs synchronous to mclk_i; one avalon-mm slave
// Notes:   control may come from pins or from the ctrl register
`timescale 1ns/1ns
`include "sudc_cfg.svh"

module sudc_top
  import sudc_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter bit DECADE = 1'b1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic load_n_i,
  input wire logic enp_n_i,
  input wire logic ent_n_i,
  input wire logic up_i,
  output logic [WIDTH-1:0] count_o,
  output logic count_bit0_o,
  output logic carry_n_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: the logic is written for four bits only
  if (WIDTH != 4) begin : g_width_chk
    $error("sudc_top supports WIDTH of 4 only");
  end

  sudc_count_t count_r;
  sudc_count_t count_nxt;
  logic [3:0] ctrl_r;
  sudc_count_t sw_data_r;
  logic sw_load_r;
  logic [31:0] rdata_r;
  logic acc_w;
  logic wr_w;
  logic rd_w;
  sudc_mode_e mode_w;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  sudc_avs u_avs (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .acc_o(acc_w),
    .wr_o(wr_w),
    .rd_o(rd_w)
  );

  // address decode
  wire sel_ctrl_w = (avs_address_i == `SUDC_CTRL_OFS);
  wire sel_data_w = (avs_address_i == `SUDC_DATA_OFS);
  wire sel_cmd_w = (avs_address_i == `SUDC_CMD_OFS);
  wire sel_stat_w = (avs_address_i == `SUDC_STAT_OFS);
  wire wr_lo_w = wr_w & avs_byteenable_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // effective controls: pins or the software copy
  wire src_sw_w = ctrl_r[`SUDC_CTRL_SRC_BIT];
  wire up_w = src_sw_w ? ctrl_r[`SUDC_CTRL_UP_BIT] : up_i;
  wire enp_n_w = src_sw_w ? ctrl_r[`SUDC_CTRL_ENP_BIT] : enp_n_i;
  wire ent_n_w = src_sw_w ? ctrl_r[`SUDC_CTRL_ENT_BIT] : ent_n_i;
  // software load pulse also works in pin mode, but there it presets from data_i rather than the data copy
  wire load_n_w = load_n_i & ~sw_load_r;
  wire sudc_count_t ld_data_w = src_sw_w ? sw_data_r : sudc_count_t'(data_i);

  // mode decode; load wins over the enables
  assign mode_w = !load_n_w ? SUDC_MODE_LOAD :
                  (enp_n_w | ent_n_w) ? SUDC_MODE_HOLD :
                  up_w ? SUDC_MODE_UP : SUDC_MODE_DOWN;

  sudc_next #(
    .DECADE(DECADE)
  ) u_next (
    .cnt_i(count_r),
    .data_i(ld_data_w),
    .mode_i(mode_w),
    .nxt_o(count_nxt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // count register: all bits on one edge, mode sampled only there
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_r <= `SUDC_COUNT_RST;
    end else if (ce_i) begin
      count_r <= count_nxt;
    end
  end

  // carry: low through the whole terminal state, so in up mode it spans
  // the high phase of bit 0 and in down mode its low phase
  wire term_w = sudc_is_term(count_r, up_w, DECADE);
  assign carry_n_o = ~(term_w & ~ent_n_w);
  assign count_o = count_r;
  assign count_bit0_o = count_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // software registers; the load command is a one-cycle pulse
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= `SUDC_CTRL_RST;
      sw_data_r <= `SUDC_DATA_RST;
      sw_load_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_lo_w && sel_ctrl_w) begin
        ctrl_r <= avs_writedata_i[3:0];
      end
      if (wr_lo_w && sel_data_w) begin
        sw_data_r <= avs_writedata_i[3:0];
      end
      sw_load_r <= wr_lo_w & sel_cmd_w & avs_writedata_i[`SUDC_CMD_LOAD_BIT];
    end
  end

  // read mux; unmapped offsets and the cmd register read as zero
  wire [31:0] stat_w = {26'h0, DECADE, carry_n_o, count_r};
  wire [31:0] rmux_w = sel_ctrl_w ? {28'h0, ctrl_r} :
                       sel_data_w ? {28'h0, sw_data_r} :
                       sel_stat_w ? stat_w : 32'h0;

  // read data captured in the wait cycle, so it stands when waitrequest drops
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h0;
    end else if (rd_w) begin
      rdata_r <= rmux_w;
    end
  end
  assign avs_readdata_o = rdata_r;

endmodule : sudc_top

/* test/sudc_props.sv */
// Purpose: pin-level checks of counting, load and carry
// Assumes: pin relations only hold while the ctrl source bit is clear
// Notes:   software load through cmd is outside these relations
`timescale 1ns/1ns
module sudc_props #(
  parameter int WIDTH = 4,
  parameter bit DECADE = 1'b1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic load_n_i,
  input wire logic enp_n_i,
  input wire logic ent_n_i,
  input wire logic up_i,
  input wire logic [WIDTH-1:0] count_o,
  input wire logic carry_n_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o
);
  localparam logic [3:0] MX = DECADE ? 4'h9 : 4'hF;
  // source bit as last written over the bus; the up, enable and data pins stop mattering while it is set, load_n_i and ce_i still act
  logic sw_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_r <= 1'b0;
    end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                 && avs_address_i == 4'h0) begin
      sw_r <= avs_writedata_i[0];
    end
  end
  wire pin = !sw_r;
  // counting edge, shared by three checks, and terminal state, used by the carry check
  wire run = pin && ce_i && load_n_i && !enp_n_i && !ent_n_i;
  wire term = up_i ? count_o == MX : count_o == 4'h0;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  property p_load; pin && ce_i && !load_n_i |=> count_o == $past(data_i); endproperty
  a_load: assert property (p_load) else $error("load missed");
  property p_hold;
    pin && ce_i && load_n_i && (enp_n_i || ent_n_i) |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while off");
  property p_up; run && up_i && count_o < MX |=> count_o == $past(count_o) + 4'h1; endproperty
  a_up: assert property (p_up) else $error("bad up step");
  property p_top; run && up_i && count_o == MX |=> count_o == 4'h0; endproperty
  a_top: assert property (p_top) else $error("no wrap at top");
  property p_bot; run && !up_i && count_o == 4'h0 |=> count_o == MX; endproperty
  a_bot: assert property (p_bot) else $error("no wrap at zero");
  property p_frz; !ce_i |=> $stable(count_o); endproperty
  a_frz: assert property (p_frz) else $error("count moved off edge");
  property p_gate; pin && ent_n_i |-> carry_n_o; endproperty
  a_gate: assert property (p_gate) else $error("carry not gated");
  property p_carry; pin |-> carry_n_o == !(!ent_n_i && term); endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
endmodule : sudc_props

bind sudc_top sudc_props #(.WIDTH(WIDTH), .DECADE(DECADE)) sudc_props_i (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .data_i(data_i), .load_n_i(load_n_i),
  .enp_n_i(enp_n_i), .ent_n_i(ent_n_i), .up_i(up_i), .count_o(count_o), .carry_n_o(carry_n_o),
  .avs_address_i(avs_address_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o));

/* test/sudc_casc.sv */
// Purpose: controlling logic that may preset the stage from its carry
// Assumes: carry_n_i comes straight from the counter
// Notes:   pure wiring, as between cascaded stages
`timescale 1ns/1ns
module sudc_casc (
  input wire logic casc_i,
  input wire logic ld_n_i,
  input wire logic carry_n_i,
  output logic load_n_o
);
  // carry low reloads the stage at the next edge
  assign load_n_o = casc_i ? carry_n_i : ld_n_i;
endmodule : sudc_casc

/* test/sudc_top_test.sv */
// Purpose: directed checks of load, counting, carry and registers
// Assumes: decade and binary builds side by side on the same pins and bus
// Notes:   expected counts worked out by hand per step
`timescale 1ns/1ns
module sudc_top_test;
  logic mclk_i = 1'b0, nrst_i = 1'b0, ce = 1'b1, ld_n = 1'b1, enp_n = 1'b1;
  logic ent_n = 1'b1, up = 1'b1, casc = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [3:0] data = 4'h0, adr = 4'h0, be = 4'h0;
  logic [31:0] wdat = 32'h0, q;
  wire [3:0] count;
  wire b0, carry_n, load_n, wait_r;
  wire [31:0] rdat;
  wire [3:0] bcount;
  wire bcarry_n;
  int bad_count = 0, compares = 0;
  sudc_casc sudc_casc_i (.casc_i(casc), .ld_n_i(ld_n), .carry_n_i(carry_n), .load_n_o(load_n));
  sudc_top #(.WIDTH(4), .DECADE(1'b1)) sudc_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .ce_i(ce), .data_i(data), .load_n_i(load_n), .enp_n_i(enp_n), .ent_n_i(ent_n), .up_i(up),
    .count_o(count), .count_bit0_o(b0), .carry_n_o(carry_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r));
  // binary build, only its count and carry are compared
  sudc_top #(.WIDTH(4), .DECADE(1'b0)) sudc_top_bin_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .ce_i(ce), .data_i(data), .load_n_i(load_n), .enp_n_i(enp_n), .ent_n_i(ent_n), .up_i(up),
    .count_o(bcount), .count_bit0_o(), .carry_n_o(bcarry_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(), .avs_waitrequest_o());
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // new pins at the edge; count from the previous pins checked just after it
  task automatic go(input logic [4:0] m, input logic [3:0] d, input logic [3:0] e);
    @(posedge mclk_i);
    {ce, ld_n, enp_n, ent_n, up} <= m;
    data <= d;
    #1;
    chk(count, e);
    chk(b0, e[0]);
  endtask : go
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] m, output logic [31:0] r);
    @(posedge mclk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    be <= m;
    do begin
      @(posedge mclk_i);
    end while (wait_r !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic t_load;
    go(5'b10111, 4'h5, 4'h0);
    go(5'b10001, 4'h8, 4'h5);
    go(5'b11001, 4'h0, 4'h8);
  endtask : t_load
  // enables change on four of the six steps, never waiting on a clock phase
  task automatic t_count;
    go(5'b11001, 4'h0, 4'h9);
    chk(carry_n, 1'b0);
    go(5'b11101, 4'h0, 4'h0);
    chk(carry_n, 1'b1);
    chk(bcount, 4'hA);
    go(5'b11100, 4'h0, 4'h0);
    chk(carry_n, 1'b0);
    chk(bcarry_n, 1'b1);
    go(5'b11010, 4'h0, 4'h0);
    chk(carry_n, 1'b1);
    go(5'b11000, 4'h0, 4'h0);
    go(5'b11111, 4'h0, 4'h9);
  endtask : t_count
  task automatic t_ce;
    go(5'b01001, 4'h0, 4'h9);
    go(5'b00111, 4'h2, 4'h9);
    go(5'b11111, 4'h0, 4'h9);
    go(5'b11111, 4'h0, 4'h9);
  endtask : t_ce
  task automatic t_casc;
    @(posedge mclk_i);
    casc <= 1'b1;
    go(5'b11001, 4'h3, 4'h9);
    go(5'b11001, 4'h3, 4'h3);
    go(5'b11111, 4'h0, 4'h4);
    @(posedge mclk_i);
    casc <= 1'b0;
  endtask : t_casc
  // status, reset value, masked write, unmapped and write-only places
  task automatic t_bus;
    bus(1'b0, 4'hC, 32'h0, 4'h0, q);
    chk(q, 32'h34);
    bus(1'b0, 4'h0, 32'h0, 4'h0, q);
    chk(q, 32'hC);
    bus(1'b1, 4'h4, 32'hA, 4'h1, q);
    bus(1'b1, 4'h4, 32'h5, 4'h0, q);
    bus(1'b0, 4'h4, 32'h0, 4'h0, q);
    chk(q, 32'hA);
    bus(1'b0, 4'h2, 32'h0, 4'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 4'h8, 32'h0, 4'h0, q);
    chk(q, 32'h0);
  endtask : t_bus
  // register source overrides the held pins; cmd loads the data copy, not data_i
  task automatic t_sw;
    bus(1'b1, 4'h0, 32'hD, 4'h1, q);
    bus(1'b1, 4'h8, 32'h1, 4'h1, q);
    bus(1'b0, 4'hC, 32'h0, 4'h0, q);
    chk(q, 32'h3A);
    bus(1'b1, 4'h0, 32'h1, 4'h1, q);
    bus(1'b1, 4'h0, 32'hD, 4'h1, q);
    @(posedge mclk_i);
    #1;
    chk(count, 4'h7);
    chk(bcount, 4'h7);
  endtask : t_sw
  task automatic complete_run;
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  // watchdog, far beyond the fewer than one hundred cycles the run needs
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_load();
    t_count();
    t_ce();
    t_casc();
    t_bus();
    t_sw();
    complete_run();
  end
endmodule : sudc_top_test
